// ===== core/rxil_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Each of the seven alarms sets its sticky bit (6 refclk .. 0 quality) and it holds.
// - The interrupt rises only for a set sticky bit, with the gate at 1 and the bit unmasked.
// - Writing 0 to a sticky bit clears it and removes its interrupt share.
// - Turning the global interrupt gate off clears all pending sticky bits.
// - Bits 7:4 of multiplier setup pick the bandwidth; only 0100 (380 kHz, default) is valid; the code takes and reads back any value written.
// - With bit 6 of lock setup at 1, signal loss forces the unlock indication.
// - With bit 5 at 1, signal loss forces lock to reference.
// - During lock to reference, bit 4 at 0 tracks the reference (only with bit 0 at 1), at 1 keeps chasing data.
// - Bit 3 at 0 takes the detect basis from the multiplier mode and shows it in bit 2.
// - Detect basis 0 uses frequency difference, 1 uses the signal quality monitor.
// - Bit 1 at 1 holds clock recovery locked to the reference clock.
// - Bit 0 at 0 means the reference clock is not used for reception.
// - A mask bit at 1 hides its alarm from the interrupt, at 0 passes it.
// - The global gate at 1 allows interrupts and at 0 blocks them all.
module rxil_regs
  import rxil_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Alarm detectors and interrupt control
  input rxil_alarm_t ALARM_IN,
  input wire logic GLOBAL_IRQ_GATE,
  input wire logic [6:0] IRQ_MASK,
  input wire logic MULTIPLIER_QUALITY_MODE,
  // Results
  output logic IRQ,
  output logic [3:0] MULT_BW_SEL,
  output logic UNLOCKED_ALARM,
  output rxil_rx_ctrl_t RX_CTRL
);

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
    hits = (addr == ofs);
  endfunction

  logic [6:0] sticky_ff;
  logic [2:0] mult_keep_ff;
  logic [6:0] lock_ff;
  logic gate_ff;
  logic [6:0] eff_alarm;
  logic [6:0] clr_vec;
  logic [6:0] nxt_sticky;
  logic wr_sticky;
  logic wr_mult;
  logic wr_lock;
  logic gate_fall;
  logic basis;
  logic raw_unlock;
  logic nxt_unlocked;
  logic refhold_act;
  logic nxt_irq;
  logic [7:0] nxt_rdata;
  rxil_rx_ctrl_t nxt_ctrl;

  assign wr_sticky = REG_WR && hits(REG_ADDR, OFS_STICKY);
  assign wr_mult = REG_WR && hits(REG_ADDR, OFS_MULT);
  assign wr_lock = REG_WR && hits(REG_ADDR, OFS_LOCK);
  assign gate_fall = gate_ff && !GLOBAL_IRQ_GATE;

  // Lock-loss alarm source is the forced unlock indication
  always_comb begin
    eff_alarm = ALARM_IN;
    eff_alarm[BIT_UNLOCKED] = UNLOCKED_ALARM;
  end

  assign clr_vec = wr_sticky ? (~REG_WDATA[6:0] & ~eff_alarm) : 7'h00;

  // Sticky bits, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < N_ALARM; gi++) begin : g_sticky
      always_comb begin
        if (eff_alarm[gi]) begin
          nxt_sticky[gi] = 1'b1;
        // clear by write or gate off
        end else if ((wr_sticky && !REG_WDATA[gi]) || gate_fall) begin
          nxt_sticky[gi] = 1'b0;
        end else begin
          nxt_sticky[gi] = sticky_ff[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sticky_ff <= RST_STICKY;
    end else begin
      sticky_ff <= nxt_sticky;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      gate_ff <= 1'b0;
    end else begin
      gate_ff <= GLOBAL_IRQ_GATE;
    end
  end

  assign nxt_irq = GLOBAL_IRQ_GATE && (|(sticky_ff & ~IRQ_MASK));

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= nxt_irq;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      MULT_BW_SEL <= RST_MULT_BW;
      mult_keep_ff <= RST_MULT_KEEP;
    end else if (wr_mult) begin
      MULT_BW_SEL <= REG_WDATA[MULT_BW_MSB:MULT_BW_LSB];
      mult_keep_ff <= REG_WDATA[MULT_KEEP_MSB:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lock_ff <= RST_LOCK;
    end else if (wr_lock) begin
      lock_ff <= REG_WDATA[6:0];
    end
  end

  assign basis = lock_ff[LOCK_MODE_OVERRIDE] ? lock_ff[LOCK_DETECT_BASIS]
                                             : MULTIPLIER_QUALITY_MODE;
  assign raw_unlock = basis ? ALARM_IN.signal_quality_alarm : ALARM_IN.unlocked_alarm;
  assign nxt_unlocked = raw_unlock ||
                        (lock_ff[LOCK_UNLOCK_ON_SA] && ALARM_IN.signal_absent_alarm);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      UNLOCKED_ALARM <= 1'b0;
    end else begin
      UNLOCKED_ALARM <= nxt_unlocked;
    end
  end

  assign refhold_act = lock_ff[LOCK_REFHOLD] ||
                       (lock_ff[LOCK_REFHOLD_ON_SA] && ALARM_IN.signal_absent_alarm);

  always_comb begin
    nxt_ctrl.refhold_active = refhold_act;
    nxt_ctrl.cdr_track_ref = refhold_act && !lock_ff[LOCK_KEEP_DATA] &&
                             lock_ff[LOCK_REF_PRESENT];
    nxt_ctrl.cdr_keep_data = refhold_act && lock_ff[LOCK_KEEP_DATA];
    nxt_ctrl.refclk_use = lock_ff[LOCK_REF_PRESENT];
    nxt_ctrl.unlock_basis_quality = basis;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RX_CTRL <= '0;
    end else begin
      RX_CTRL <= nxt_ctrl;
    end
  end

  always_comb begin
    if (hits(REG_ADDR, OFS_STICKY)) begin
      nxt_rdata = {1'b0, sticky_ff};
    end else if (hits(REG_ADDR, OFS_MULT)) begin
      nxt_rdata = {MULT_BW_SEL, 1'b0, mult_keep_ff};
    end else if (hits(REG_ADDR, OFS_LOCK)) begin
      nxt_rdata = {1'b0, lock_ff[6:3], basis, lock_ff[1:0]};
    end else begin
      nxt_rdata = RST_RDATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= RST_RDATA;
    end else begin
      REG_RDATA <= nxt_rdata;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  a_sticky_sets: assert property (
    (|eff_alarm) |=> ((sticky_ff & $past(eff_alarm)) == $past(eff_alarm)))
    else $error("Active alarm did not set its sticky bit");

  a_sticky_holds: assert property (
    (!wr_sticky && !gate_fall) |=> ((sticky_ff & $past(sticky_ff)) == $past(sticky_ff)))
    else $error("Sticky bit dropped without a clear");

  a_irq_raise: assert property (
    (GLOBAL_IRQ_GATE && (|(sticky_ff & ~IRQ_MASK))) |=> IRQ)
    else $error("Unmasked pending alarm gave no interrupt");

  a_irq_block: assert property (
    (!GLOBAL_IRQ_GATE || ((sticky_ff & ~IRQ_MASK) == 7'h00)) |=> !IRQ)
    else $error("Interrupt without gated unmasked alarm");

  a_write_clear: assert property (
    (|clr_vec) |=> ((sticky_ff & $past(clr_vec)) == 7'h00))
    else $error("Written zero did not clear sticky bit");

  a_gate_clear: assert property (
    (gate_fall && (eff_alarm == 7'h00)) |=> (sticky_ff == 7'h00))
    else $error("Gate off did not clear pending bits");

  a_set_wins: assert property (
    (wr_sticky && (|(eff_alarm & ~REG_WDATA[6:0])))
      |=> ((sticky_ff & $past(eff_alarm)) == $past(eff_alarm)))
    else $error("Clear beat a simultaneous alarm");

  a_reserved_zero: assert property (
    (hits(REG_ADDR, OFS_STICKY) || hits(REG_ADDR, OFS_LOCK)) |=> !REG_RDATA[7])
    else $error("Reserved bit 7 read as one");

  a_mult_bit3: assert property (
    hits(REG_ADDR, OFS_MULT) |=> !REG_RDATA[3])
    else $error("Multiplier reserved bit 3 read as one");

  a_bw_write: assert property (
    wr_mult |=> (MULT_BW_SEL == $past(REG_WDATA[7:4])))
    else $error("Bandwidth field not taken");

  a_unlock_force: assert property (
    (lock_ff[LOCK_UNLOCK_ON_SA] && ALARM_IN.signal_absent_alarm && !wr_lock)
      |=> UNLOCKED_ALARM)
    else $error("Signal loss did not force unlock");

  a_refhold_force: assert property (
    (lock_ff[LOCK_REFHOLD_ON_SA] && ALARM_IN.signal_absent_alarm) |=> RX_CTRL.refhold_active)
    else $error("Signal loss did not force lock to reference");

  a_keep_data: assert property (
    (refhold_act && lock_ff[LOCK_KEEP_DATA])
      |=> (RX_CTRL.cdr_keep_data && !RX_CTRL.cdr_track_ref))
    else $error("Data acquisition option not honoured");

  a_basis_auto: assert property (
    (!lock_ff[LOCK_MODE_OVERRIDE] && hits(REG_ADDR, OFS_LOCK) && !wr_lock)
      |=> (REG_RDATA[2] == $past(MULTIPLIER_QUALITY_MODE)))
    else $error("Automatic detect basis not reported");

  a_basis_pick: assert property (
    (lock_ff[LOCK_MODE_OVERRIDE] && lock_ff[LOCK_DETECT_BASIS] && !wr_lock &&
     !lock_ff[LOCK_UNLOCK_ON_SA])
      |=> (UNLOCKED_ALARM == $past(ALARM_IN.signal_quality_alarm)))
    else $error("Quality basis not used for unlock");

  a_refhold_cmd: assert property (
    lock_ff[LOCK_REFHOLD] |=> RX_CTRL.refhold_active)
    else $error("Lock to reference not applied");

  a_ref_unused: assert property (
    !lock_ff[LOCK_REF_PRESENT] |=> (!RX_CTRL.refclk_use && !RX_CTRL.cdr_track_ref))
    else $error("Absent reference clock still used");

  a_mask_hides: assert property (
    ((sticky_ff & ~IRQ_MASK) == 7'h00) |=> !IRQ)
    else $error("Masked alarm reached interrupt");

  a_unlock_sticky: assert property (
    UNLOCKED_ALARM |=> sticky_ff[BIT_UNLOCKED])
    else $error("Unlock indication did not set its sticky bit");

  a_track_ref: assert property (
    (refhold_act && !lock_ff[LOCK_KEEP_DATA] && lock_ff[LOCK_REF_PRESENT])
      |=> (RX_CTRL.cdr_track_ref && !RX_CTRL.cdr_keep_data))
    else $error("Recovery loop not tracking reference");

  a_refclk_use: assert property (
    lock_ff[LOCK_REF_PRESENT] |=> RX_CTRL.refclk_use)
    else $error("Present reference clock not used");

  a_freq_basis: assert property (
    (!lock_ff[LOCK_UNLOCK_ON_SA] && !lock_ff[LOCK_MODE_OVERRIDE] && !MULTIPLIER_QUALITY_MODE)
      |=> (UNLOCKED_ALARM == $past(ALARM_IN.unlocked_alarm)))
    else $error("Frequency basis not used for unlock");

  c_irq_fire: cover property (GLOBAL_IRQ_GATE && !IRQ ##1 IRQ);
  c_unlock_forced: cover property (lock_ff[LOCK_UNLOCK_ON_SA] && ALARM_IN.signal_absent_alarm ##1 UNLOCKED_ALARM);
  c_clear_write: cover property (IRQ ##1 (|clr_vec) ##2 !IRQ);
  c_set_wins: cover property (wr_sticky && (|(eff_alarm & ~REG_WDATA[6:0])));
  c_gate_off: cover property ((sticky_ff != 7'h00) && gate_fall);

endmodule

// ===== shared/rxil_pkg.sv
package rxil_pkg;

  // Register offsets on the register port
  localparam logic [7:0] OFS_STICKY = 8'h05;
  localparam logic [7:0] OFS_MULT = 8'h06;
  localparam logic [7:0] OFS_LOCK = 8'h07;

  localparam int N_ALARM = 7;

  // Alarm bit positions in the sticky register
  localparam int BIT_REFCLK_ABSENT = 6;
  localparam int BIT_SIGNAL_ABSENT = 5;
  localparam int BIT_UNLOCKED = 4;
  localparam int BIT_BUFFER_FAULT = 3;
  localparam int BIT_PATTERN_MISMATCH = 2;
  localparam int BIT_PATTERN_SYNC = 1;
  localparam int BIT_SIGNAL_QUALITY = 0;

  // Clock multiplier setup fields
  localparam int MULT_BW_LSB = 4;
  localparam int MULT_BW_MSB = 7;
  localparam int MULT_KEEP_MSB = 2;

  // Lock behaviour setup fields
  localparam int LOCK_UNLOCK_ON_SA = 6;
  localparam int LOCK_REFHOLD_ON_SA = 5;
  localparam int LOCK_KEEP_DATA = 4;
  localparam int LOCK_MODE_OVERRIDE = 3;
  localparam int LOCK_DETECT_BASIS = 2;
  localparam int LOCK_REFHOLD = 1;
  localparam int LOCK_REF_PRESENT = 0;

  // Values after reset
  localparam logic [6:0] RST_STICKY = 7'h00;
  localparam logic [3:0] BW_380K = 4'h4;
  localparam logic [3:0] RST_MULT_BW = BW_380K;
  localparam logic [2:0] RST_MULT_KEEP = 3'h0;
  localparam logic [6:0] RST_LOCK = 7'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // Alarm levels, bit 6 down to bit 0 as in the sticky register
  typedef struct packed {
    logic refclk_absent_alarm;
    logic signal_absent_alarm;
    logic unlocked_alarm;
    logic rx_buffer_fault;
    logic pattern_mismatch_alarm;
    logic pattern_sync_dropped;
    logic signal_quality_alarm;
  } rxil_alarm_t;

  // Receive clock recovery controls
  typedef struct packed {
    logic refhold_active;
    logic cdr_track_ref;
    logic cdr_keep_data;
    logic refclk_use;
    logic unlock_basis_quality;
  } rxil_rx_ctrl_t;

endpackage

// ===== verification/tb.sv
`timescale 1ns/1ps
module tb;
  import rxil_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  rxil_alarm_t alarm_in = 7'h00;
  logic irq_gate = 1'b0;
  logic [6:0] irq_mask = 7'h00;
  logic qual_mode = 1'b0;
  logic irq;
  logic [3:0] bw_sel;
  logic unlocked;
  rxil_rx_ctrl_t rx_ctrl;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  rxil_regs u_rxil_regs (
    .REF_CLK(ref_clk),
    .RST(rst),
    .REG_WR(reg_wr),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata),
    .ALARM_IN(alarm_in),
    .GLOBAL_IRQ_GATE(irq_gate),
    .IRQ_MASK(irq_mask),
    .MULTIPLIER_QUALITY_MODE(qual_mode),
    .IRQ(irq),
    .MULT_BW_SEL(bw_sel),
    .UNLOCKED_ALARM(unlocked),
    .RX_CTRL(rx_ctrl)
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, run needs under two hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(negedge ref_clk);
    chk("rdata", exp, reg_rdata);
  endtask

  task automatic pulse(input int k);
    alarm_in[k] = 1'b1;
    step(1);
    alarm_in = 7'h00;
  endtask

  task automatic t_reset;
    rd(OFS_STICKY, 8'h00);
    rd(OFS_MULT, 8'h40);
    rd(OFS_LOCK, 8'h00);
    chk("bw_sel", 8'h04, {4'h0, bw_sel});
    chk("irq", 8'h00, {7'h00, irq});
  endtask

  task automatic t_reserved;
    wr(OFS_STICKY, 8'hff);
    rd(OFS_STICKY, 8'h00);
    wr(OFS_MULT, 8'hf8);
    rd(OFS_MULT, 8'hf0);
    chk("bw_sel", 8'h0f, {4'h0, bw_sel});
    wr(OFS_MULT, 8'h40);
    wr(OFS_LOCK, 8'hff);
    rd(OFS_LOCK, 8'h7f);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h00);
    rd(8'h04, 8'h00);
    wr(OFS_LOCK, 8'h08);
  endtask

  task automatic t_sticky;
    irq_gate = 1'b1;
    for (int k = 0; k < N_ALARM; k++) begin
      pulse(k);
      step(3);
      rd(OFS_STICKY, 8'h01 << k);
      chk("irq", 8'h01, {7'h00, irq});
      wr(OFS_STICKY, 8'h00);
      step(2);
      chk("irq", 8'h00, {7'h00, irq});
      rd(OFS_STICKY, 8'h00);
    end
  endtask

  task automatic t_gate_mask;
    irq_mask = 7'h7f;
    pulse(2);
    step(3);
    chk("irq", 8'h00, {7'h00, irq});
    rd(OFS_STICKY, 8'h04);
    irq_mask = 7'h7b;
    step(2);
    chk("irq", 8'h01, {7'h00, irq});
    irq_gate = 1'b0;
    step(2);
    chk("irq", 8'h00, {7'h00, irq});
    rd(OFS_STICKY, 8'h00);
    irq_gate = 1'b1;
    step(2);
    chk("irq", 8'h00, {7'h00, irq});
    irq_gate = 1'b0;
    step(3);
    pulse(6);
    step(3);
    rd(OFS_STICKY, 8'h40);
    chk("irq", 8'h00, {7'h00, irq});
    irq_mask = 7'h00;
    irq_gate = 1'b1;
    step(2);
    chk("irq", 8'h01, {7'h00, irq});
    wr(OFS_STICKY, 8'h00);
  endtask

  task automatic t_set_wins;
    alarm_in[3] = 1'b1;
    wr(OFS_STICKY, 8'h00);
    alarm_in = 7'h00;
    rd(OFS_STICKY, 8'h08);
    wr(OFS_STICKY, 8'h00);
    rd(OFS_STICKY, 8'h00);
  endtask

  // Columns: setup, alarms, multiplier mode, {unlocked, rx_ctrl}
  task automatic t_lock;
    logic [7:0] cfg[11];
    logic [6:0] al[11];
    logic qm[11];
    logic [5:0] ex[11];
    cfg = '{8'h03, 8'h13, 8'h21, 8'h21, 8'h40, 8'h40, 8'h00, 8'h0c, 8'h08, 8'h08, 8'h02};
    al = '{7'h00, 7'h00, 7'h20, 7'h00, 7'h20, 7'h00, 7'h00, 7'h01, 7'h01, 7'h10, 7'h00};
    qm = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    ex = '{6'h1a, 6'h16, 6'h1a, 6'h02, 6'h20, 6'h00, 6'h01, 6'h21, 6'h00, 6'h20, 6'h10};
    irq_mask = 7'h7f;
    for (int i = 0; i < 11; i++) begin
      wr(OFS_LOCK, cfg[i]);
      alarm_in = rxil_alarm_t'(al[i]);
      qual_mode = qm[i];
      step(2);
      chk("lock_ctrl", {2'b00, ex[i]}, {2'b00, unlocked, rx_ctrl});
      rd(OFS_LOCK, (cfg[i] & 8'h7b) | {5'h00, ex[i][0], 2'b00});
    end
    alarm_in = 7'h00;
    qual_mode = 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_reserved();
    t_sticky();
    t_gate_mask();
    t_set_wins();
    t_lock();
    end_of_test();
  end
endmodule
